// file: eps_pause_user.sv
// User end: pause controller with AXI4-Lite registers
`timescale 1ns/1ps
module eps_pause_user
    import eps_pkg::*;
#(
    parameter int TICK_CYCLES = QUANTUM_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    eps_if.usr pif,
    input wire logic [EPS_QW-1:0] txQuantaIn [EPS_IDX],
    input wire logic [EPS_QW-1:0] txIntervalIn [EPS_IDX],
    input wire logic [EPS_IDX-1:0] txGateIn,
    output logic [EPS_IDX-1:0] pausedOut,
    output logic irq,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************
    // Register slave
    // ****************************************
    logic [8:0] txReq_reg;
    logic [8:0] status_reg;
    logic [8:0] mask_reg;
    logic [3:0] wAddr_reg;
    logic [31:0] wData_reg;
    logic haveAw_reg;
    logic haveW_reg;
    logic [EPS_IDX-1:0] busyVec;
    wire awFire = s_axi_awvalid && s_axi_awready;
    wire wFire = s_axi_wvalid && s_axi_wready;
    wire doWrite = haveAw_reg && haveW_reg && !s_axi_bvalid;
    wire wLow = s_axi_wstrb[0] || s_axi_wstrb[1];
    wire hitReq = doWrite && wLow && (wAddr_reg == REG_TXREQ);
    wire hitStat = doWrite && wLow && (wAddr_reg == REG_STATUS);
    wire hitMask = doWrite && wLow && (wAddr_reg == REG_MASK);
    wire wMapped = (wAddr_reg == REG_TXREQ) || (wAddr_reg == REG_STATUS)
        || (wAddr_reg == REG_MASK) || (wAddr_reg == REG_PAUSED);
    wire [8:0] clrBits = hitStat ? wData_reg[8:0] : '0;
    // New pause arrival beats a same-cycle clear
    wire [8:0] status_next = (status_reg & ~clrBits) | pif.rxPauseValid;
    wire [3:0] ra = s_axi_araddr;
    wire rdMapped = (ra == REG_TXREQ) || (ra == REG_STATUS)
        || (ra == REG_MASK) || (ra == REG_PAUSED);
    wire [8:0] rdSel = (ra == REG_TXREQ) ? txReq_reg
        : (ra == REG_STATUS) ? status_reg
        : (ra == REG_MASK) ? mask_reg
        : (ra == REG_PAUSED) ? busyVec : 9'h000;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            haveAw_reg <= 1'b0;
            haveW_reg <= 1'b0;
            wAddr_reg <= '0;
            wData_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (awFire)
            begin
                wAddr_reg <= s_axi_awaddr;
                haveAw_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (wFire)
            begin
                wData_reg <= s_axi_wdata;
                haveW_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
                haveAw_reg <= 1'b0;
                haveW_reg <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {23'h000000, rdSel};
            s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txReq_reg <= TXREQ_RESET;
            status_reg <= STATUS_RESET;
            mask_reg <= MASK_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (hitReq)
                txReq_reg <= wData_reg[8:0];
            if (hitMask)
                mask_reg <= wData_reg[8:0];
            status_reg <= status_next;
            irq <= |(status_next & mask_reg);
        end
    end

    // ****************************************
    // Quantum tick divider
    // ****************************************
    localparam int TW = $clog2(TICK_CYCLES + 1);
    logic [TW-1:0] div_reg;
    logic tick_reg;
    wire divWrap = (div_reg == TW'(TICK_CYCLES - 1));
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            div_reg <= divWrap ? '0 : div_reg + TW'(1);
            tick_reg <= divWrap;
        end
    end

    // ****************************************
    // Per-index pause handling
    // ****************************************
    logic [EPS_IDX-1:0] ack_reg;
    logic [EPS_IDX-1:0] txOut_reg;
    logic [EPS_IDX-1:0] gate_reg;
    logic [EPS_QW-1:0] txQ_reg [EPS_IDX];
    logic [EPS_QW-1:0] txI_reg [EPS_IDX];
    localparam int HW = $clog2(TX_HOLD_CYCLES + 1);
    genvar g;
    generate
        for (g = 0; g < EPS_IDX; g++)
        begin : g_idx
            logic [HW-1:0] hold_reg;
            wire held = (hold_reg >= HW'(TX_HOLD_CYCLES - 1));
            wire change = held && (txReq_reg[g] != txOut_reg[g]);
            eps_countdown #(
                .W(EPS_QW)
            ) u_pause (
                .clk(clk),
                .rst_n(rst_n),
                .tick(tick_reg),
                .load(pif.rxPauseValid[g]),
                .clear(1'b0),
                .value(pif.rxQuanta[g]),
                .busy(busyVec[g]),
                .expire()
            );
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    hold_reg <= '0;
                    txOut_reg[g] <= 1'b0;
                    ack_reg[g] <= 1'b0;
                    txQ_reg[g] <= '0;
                    txI_reg[g] <= '0;
                end
                else
                begin
                    if (change)
                        hold_reg <= '0;
                    else if (!held)
                        hold_reg <= hold_reg + HW'(1);
                    if (change)
                        txOut_reg[g] <= txReq_reg[g];
                    // one pulse, a fresh request is kept
                    ack_reg[g] <= pif.rxPauseRequest[g] && !ack_reg[g];
                    txQ_reg[g] <= txQuantaIn[g];
                    txI_reg[g] <= txIntervalIn[g];
                end
            end
            assign pif.txQuanta[g] = txQ_reg[g];
            assign pif.txRefreshInterval[g] = txI_reg[g];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_reg <= '0;
            pausedOut <= '0;
        end
        else
        begin
            gate_reg <= txGateIn;
            pausedOut <= busyVec;
        end
    end

    assign pif.rxPauseAcknowledge = ack_reg;
    assign pif.txPauseRequest = txOut_reg;
    assign pif.txPausePriorityGate = gate_reg;
endmodule // eps_pause_user

// file: eps_pkg.sv
// Shared constants for the pause signalling ends
package eps_pkg;
    // ****************************************
    // Bus shapes
    // ****************************************
    localparam int EPS_IDX = 9;
    localparam int EPS_PRIO = 8;
    localparam int EPS_GLB = 8;
    localparam int EPS_QW = 16;
    localparam int EPS_PIDW = 4;
    // ****************************************
    // Timing
    // ****************************************
    localparam int TX_HOLD_CYCLES = 16;
    localparam int CLK_PERIOD_PS = 100000;
    // One pause quantum is 512 bit times at 100 Gb/s
    localparam int QUANTUM_PS = 5120;
    localparam int QUANTUM_RAW = QUANTUM_PS / CLK_PERIOD_PS;
    localparam int QUANTUM_CYCLES = (QUANTUM_RAW < 1) ? 1 : QUANTUM_RAW;
    // ****************************************
    // Controller register map
    // ****************************************
    localparam logic [3:0] REG_TXREQ = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h8;
    localparam logic [3:0] REG_PAUSED = 4'hc;
    localparam logic [8:0] TXREQ_RESET = 9'h000;
    localparam logic [8:0] STATUS_RESET = 9'h000;
    localparam logic [8:0] MASK_RESET = 9'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // Transmit sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        EPS_TX_IDLE = 2'h1,
        EPS_TX_SEND = 2'h2
    } eps_tx_state_t;
endpackage

// file: eps_if.sv
// Pause signalling between the MAC end and the user logic end
`timescale 1ns/1ps
interface eps_if;
    import eps_pkg::*;
    logic [EPS_IDX-1:0] rxPauseRequest;
    logic [EPS_IDX-1:0] rxPauseAcknowledge;
    logic [EPS_IDX-1:0] rxPauseValid;
    // Index 8 carries the global pause quanta
    logic [EPS_QW-1:0] rxQuanta [EPS_IDX];
    logic [EPS_IDX-1:0] txPauseRequest;
    logic [EPS_QW-1:0] txQuanta [EPS_IDX];
    logic [EPS_QW-1:0] txRefreshInterval [EPS_IDX];
    logic [EPS_IDX-1:0] txPausePriorityGate;
    logic [EPS_IDX-1:0] txPauseValid;
    modport dev (
        output rxPauseRequest, rxPauseValid, rxQuanta, txPauseValid,
        input rxPauseAcknowledge, txPauseRequest, txQuanta,
        input txRefreshInterval, txPausePriorityGate
    );
    modport usr (
        input rxPauseRequest, rxPauseValid, rxQuanta, txPauseValid,
        output rxPauseAcknowledge, txPauseRequest, txQuanta,
        output txRefreshInterval, txPausePriorityGate
    );
endinterface // eps_if

// file: eps_countdown.sv
// Loadable down counter stepped by a tick enable
`timescale 1ns/1ps
module eps_countdown #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic load,
    input wire logic clear,
    input wire logic [W-1:0] value,
    output logic busy,
    output logic expire
);
    logic [W-1:0] count_reg;
    logic expire_reg;
    wire lastStep = tick && (count_reg == W'(1));
    assign busy = (count_reg != '0);
    assign expire = expire_reg;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
            expire_reg <= 1'b0;
        end
        else
        begin
            expire_reg <= lastStep && !clear && !load;
            if (clear)
                count_reg <= '0;
            else if (load)
                count_reg <= value;
            else if (tick && busy)
                count_reg <= count_reg - W'(1);
        end
    end
endmodule // eps_countdown

// file: eps_mac_pause.sv
// MAC end: receive pause flags and transmit pause sequencing
`timescale 1ns/1ps
// Functional notes
// - Accepted pause raises request until processed
// - User acknowledges each flagged pause bit
// - Valid pulse marks quanta ready for use
// - Global 802.3x pause flags bit 8
// - Global pause quanta on index 8
// - Eight per-priority received quanta outputs
// - Request bit sends pause with its quanta
// - Bit 8 global, bits 0-7 priority
// - User holds request 16 cycles minimum
// - User supplies nine transmit quanta values
// - Per-priority refresh interval sets resend wait
// - Index 8 interval paces global resends
// - Only gated priorities may send pause
module eps_mac_pause
    import eps_pkg::*;
#(
    parameter int TICK_CYCLES = QUANTUM_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    eps_if.dev pif,
    input wire logic rxFrameStrobe,
    input wire logic rxFrameGlobal,
    input wire logic [EPS_PRIO-1:0] rxFrameClasses,
    input wire logic [EPS_QW-1:0] rxFrameTime [EPS_PRIO],
    input wire logic [EPS_IDX-1:0] rxPauseGate,
    input wire logic txResendPause,
    input wire logic txFrameTaken,
    output logic txFrameValid,
    output logic txFrameGlobal,
    output logic [EPS_PIDW-1:0] txFrameIndex,
    output logic [EPS_QW-1:0] txFrameQuanta
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [EPS_IDX-1:0] lowestOne(
        input logic [EPS_IDX-1:0] v
    );
        lowestOne = v & (~v + EPS_IDX'(1));
    endfunction

    function automatic logic [EPS_PIDW-1:0] oneHotIndex(
        input logic [EPS_IDX-1:0] v
    );
        oneHotIndex = '0;
        for (int i = 0; i < EPS_IDX; i++)
            if (v[i])
                oneHotIndex = EPS_PIDW'(i);
    endfunction

    // ****************************************
    // Quantum tick divider
    // ****************************************
    localparam int TW = $clog2(TICK_CYCLES + 1);
    logic [TW-1:0] div_reg;
    logic tick_reg;
    wire divWrap = (div_reg == TW'(TICK_CYCLES - 1));
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            div_reg <= divWrap ? '0 : div_reg + TW'(1);
            tick_reg <= divWrap;
        end
    end

    // ****************************************
    // Receive side
    // ****************************************
    logic [EPS_IDX-1:0] rxReq_reg;
    logic [EPS_IDX-1:0] rxValid_reg;
    logic [EPS_QW-1:0] rxQuanta_reg [EPS_IDX];
    wire rxGlbHit = rxFrameStrobe && rxFrameGlobal;
    wire [EPS_PRIO-1:0] rxPrioHit =
        (rxFrameStrobe && !rxFrameGlobal) ? rxFrameClasses : '0;
    // Gate only trims what the user sees, parsing is unaffected
    wire [EPS_IDX-1:0] rxHit = {rxGlbHit, rxPrioHit} & rxPauseGate;
    wire [EPS_IDX-1:0] rxReq_next =
        rxHit | (rxReq_reg & ~pif.rxPauseAcknowledge);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxReq_reg <= '0;
            rxValid_reg <= '0;
        end
        else
        begin
            rxReq_reg <= rxReq_next;
            rxValid_reg <= rxHit;
        end
    end

    genvar g;
    generate
        for (g = 0; g < EPS_IDX; g++)
        begin : g_rxq
            wire [EPS_QW-1:0] src =
                (g == EPS_GLB) ? rxFrameTime[0] : rxFrameTime[g % EPS_PRIO];
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    rxQuanta_reg[g] <= '0;
                else if (rxHit[g])
                    rxQuanta_reg[g] <= src;
            end
            assign pif.rxQuanta[g] = rxQuanta_reg[g];
        end
    endgenerate

    assign pif.rxPauseRequest = rxReq_reg;
    assign pif.rxPauseValid = rxValid_reg;

    // ****************************************
    // Transmit launch and refresh
    // ****************************************
    logic [EPS_IDX-1:0] txReqPrev_reg;
    logic [EPS_IDX-1:0] pending_reg;
    logic [EPS_IDX-1:0] grant_reg;
    logic [EPS_IDX-1:0] txSent_reg;
    logic [EPS_IDX-1:0] expireVec;
    eps_tx_state_t state_reg;
    eps_tx_state_t state_next;

    wire [EPS_IDX-1:0] txReq = pif.txPauseRequest;
    wire [EPS_IDX-1:0] txRise = txReq & ~txReqPrev_reg;
    wire idle = (state_reg == EPS_TX_IDLE);
    wire [EPS_IDX-1:0] pick = idle ? lowestOne(pending_reg) : '0;
    wire sendDone = (state_reg == EPS_TX_SEND) && txFrameTaken;
    wire [EPS_IDX-1:0] doneVec = sendDone ? grant_reg : '0;
    wire [EPS_IDX-1:0] resendVec = txResendPause ? txReq : '0;
    wire [EPS_IDX-1:0] launch = txRise | (expireVec & txReq) | resendVec;
    // gated launch, set wins over grant
    wire [EPS_IDX-1:0] pending_next =
        ((pending_reg & ~pick) | launch) & pif.txPausePriorityGate;

    generate
        for (g = 0; g < EPS_IDX; g++)
        begin : g_refresh
            eps_countdown #(
                .W(EPS_QW)
            ) u_refresh (
                .clk(clk),
                .rst_n(rst_n),
                .tick(tick_reg),
                .load(doneVec[g]),
                .clear(!txReq[g] || txResendPause),
                .value(pif.txRefreshInterval[g]),
                .busy(),
                .expire(expireVec[g])
            );
        end
    endgenerate

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            EPS_TX_IDLE:
                if (|pending_reg)
                    state_next = EPS_TX_SEND;
            EPS_TX_SEND:
                if (txFrameTaken)
                    state_next = EPS_TX_IDLE;
            default:
                state_next = EPS_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= EPS_TX_IDLE;
            txReqPrev_reg <= '0;
            pending_reg <= '0;
            txSent_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            txReqPrev_reg <= txReq;
            pending_reg <= pending_next;
            txSent_reg <= doneVec;
        end
    end

    // Frame fields stay frozen while the MAC has not taken them
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            grant_reg <= '0;
            txFrameValid <= 1'b0;
            txFrameGlobal <= 1'b0;
            txFrameIndex <= '0;
            txFrameQuanta <= '0;
        end
        else if (idle && (|pending_reg))
        begin
            grant_reg <= pick;
            txFrameValid <= 1'b1;
            txFrameGlobal <= pick[EPS_GLB];
            txFrameIndex <= oneHotIndex(pick);
            txFrameQuanta <= pif.txQuanta[oneHotIndex(pick)];
        end
        else if (sendDone)
        begin
            txFrameValid <= 1'b0;
        end
    end

    assign pif.txPauseValid = txSent_reg;
endmodule // eps_mac_pause

// file: eps_pause_monitor.sv
// Checker on the pause signals between the two ends
`timescale 1ns/1ps
module eps_pause_monitor
    import eps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [EPS_IDX-1:0] rxPauseRequest,
    input wire logic [EPS_IDX-1:0] rxPauseAcknowledge,
    input wire logic [EPS_IDX-1:0] rxPauseValid,
    input wire logic [EPS_IDX-1:0] txPauseRequest,
    input wire logic [EPS_IDX-1:0] txPausePriorityGate,
    input wire logic [EPS_IDX-1:0] txPauseValid
);
    // ********
    // Interface rules
    // ********
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_valid_with_req: assert property (
        (rxPauseValid & ~rxPauseRequest) == 9'h000)
        else $error("pause valid without request");
    chk_req_until_ack: assert property (
        ($past(rxPauseRequest) & ~rxPauseRequest
        & ~$past(rxPauseAcknowledge)) == 9'h000)
        else $error("request dropped before acknowledge");
    chk_ack_clears_req: assert property (
        ($past(rxPauseAcknowledge) & $past(rxPauseRequest)
        & rxPauseRequest & ~rxPauseValid) == 9'h000)
        else $error("request kept after acknowledge");
    chk_tx_one_frame: assert property (
        $onehot0(txPauseValid))
        else $error("two pause frames at once");
    chk_tx_pulse_gap: assert property (
        txPauseValid != 9'h000 |=> txPauseValid == 9'h000)
        else $error("pause frames without idle gap");
    chk_tx_gated: assert property (
        (txPauseValid & ~txPausePriorityGate) == 9'h000)
        else $error("pause sent for gated priority");
    chk_tx_requested: assert property (
        (txPauseValid & ~txPauseRequest) == 9'h000)
        else $error("pause sent without request");
    // Split in two runs to keep the repetition short for the tools
    for (genvar i = 0; i < EPS_IDX; i++)
    begin : g_hold
        chk_req_hold_time: assert property (
            $changed(txPauseRequest[i]) |=> $stable(txPauseRequest[i])[*8]
            ##1 $stable(txPauseRequest[i])[*7])
            else $error("request changed within hold time");
    end
    cover property (rxPauseValid[8]);
    cover property (txPauseValid[8]);
    cover property ($rose(txPauseRequest[3]) ##[1:40] txPauseValid[3]);
endmodule // eps_pause_monitor

// file: ethernet_pause_signal_interface_tb.sv
// Self-checking bench joining the MAC end and the user end
`timescale 1ns/1ps
module ethernet_pause_signal_interface_tb;
    import eps_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rxFrameStrobe = 1'b0;
    logic rxFrameGlobal = 1'b0;
    logic [EPS_PRIO-1:0] rxFrameClasses = 8'h00;
    logic [EPS_QW-1:0] rxFrameTime [EPS_PRIO];
    logic [EPS_IDX-1:0] rxPauseGate = 9'h1ff;
    logic txResendPause = 1'b0;
    // Frames are taken at once, so each launch stands one cycle
    logic txFrameTaken = 1'b1;
    logic txFrameValid;
    logic txFrameGlobal;
    logic [EPS_PIDW-1:0] txFrameIndex;
    logic [EPS_QW-1:0] txFrameQuanta;
    logic [EPS_QW-1:0] txQuantaIn [EPS_IDX];
    logic [EPS_QW-1:0] txIntervalIn [EPS_IDX];
    logic [EPS_IDX-1:0] txGateIn = 9'h1ff;
    logic [EPS_IDX-1:0] pausedOut;
    logic irq;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic got, fg;
    logic [3:0] fi;
    logic [15:0] fq;
    logic [8:0] vld, rq;
    logic [15:0] qs [EPS_IDX];
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0, wt;
    eps_if pif ();
    eps_mac_pause i_eps_mac_pause (.clk(clk), .rst_n(rst_n), .pif(pif),
        .rxFrameStrobe(rxFrameStrobe), .rxFrameGlobal(rxFrameGlobal),
        .rxFrameClasses(rxFrameClasses), .rxFrameTime(rxFrameTime),
        .rxPauseGate(rxPauseGate), .txResendPause(txResendPause),
        .txFrameTaken(txFrameTaken), .txFrameValid(txFrameValid),
        .txFrameGlobal(txFrameGlobal), .txFrameIndex(txFrameIndex),
        .txFrameQuanta(txFrameQuanta));
    eps_pause_user i_eps_pause_user (.clk(clk), .rst_n(rst_n), .pif(pif),
        .txQuantaIn(txQuantaIn), .txIntervalIn(txIntervalIn),
        .txGateIn(txGateIn), .pausedOut(pausedOut), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    eps_pause_monitor i_eps_pause_monitor (.clk(clk), .rst_n(rst_n),
        .rxPauseRequest(pif.rxPauseRequest),
        .rxPauseAcknowledge(pif.rxPauseAcknowledge),
        .rxPauseValid(pif.rxPauseValid), .txPauseRequest(pif.txPauseRequest),
        .txPausePriorityGate(pif.txPausePriorityGate),
        .txPauseValid(pif.txPauseValid));
    // ********
    // Tasks
    // ********
    always #50 clk = ~clk;
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            give_verdict;
        end
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task axi_rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask
    task rx_frame(input logic g, input logic [7:0] c);
        @(posedge clk);
        rxFrameStrobe <= 1'b1;
        rxFrameGlobal <= g;
        rxFrameClasses <= c;
        @(posedge clk);
        rxFrameStrobe <= 1'b0;
        got = 1'b0;
        repeat (4)
        begin
            @(posedge clk);
            if (!got && pif.rxPauseValid != 9'h000)
            begin
                got = 1'b1;
                vld = pif.rxPauseValid;
                rq = pif.rxPauseRequest;
                qs = pif.rxQuanta;
            end
        end
    endtask
    task tx_wait(input int lim);
        got = 1'b0;
        for (int n = 0; n < lim && !got; n++)
        begin
            @(posedge clk);
            if (txFrameValid === 1'b1)
            begin
                got = 1'b1;
                wt = n;
                fi = txFrameIndex;
                fq = txFrameQuanta;
                fg = txFrameGlobal;
            end
        end
    endtask
    // ********
    // Tests
    // ********
    initial
    begin
        foreach (rxFrameTime[i]) rxFrameTime[i] = 16'h0100 + 16'(i);
        foreach (txQuantaIn[i]) txQuantaIn[i] = 16'h1230 + 16'(i);
        foreach (txIntervalIn[i]) txIntervalIn[i] = 16'h0014;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a += 4)
        begin
            axi_rd(4'(a));
            check(rd, 32'h0);
        end
        axi_rd(4'h2);
        check({rs, rd}, {RESP_SLVERR, 32'h0});
        $display("test reset done");
        rx_frame(1'b0, 8'h05);
        check({vld, rq}, {9'h005, 9'h005});
        check({qs[0], qs[2]}, {16'h0100, 16'h0102});
        check(pausedOut, 9'h005);
        repeat (4) @(posedge clk);
        check(pif.rxPauseRequest, 9'h000);
        rxFrameTime[0] <= 16'h0abc;
        rx_frame(1'b1, 8'h00);
        check(vld, 9'h100);
        check(qs[8], 16'h0abc);
        // A gated-off priority must leave the user side untouched
        rxPauseGate <= 9'h1fe;
        rx_frame(1'b0, 8'h01);
        check(got, 1'b0);
        rxPauseGate <= 9'h1ff;
        axi_rd(REG_STATUS);
        check(rd, 32'h105);
        check(irq, 1'b0);
        axi_wr(REG_MASK, 32'h1ff);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        axi_wr(REG_STATUS, 32'h1ff);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        axi_wr(REG_MASK, 32'h0);
        $display("test receive done");
        axi_wr(REG_TXREQ, 32'h008);
        tx_wait(60);
        check({got, fg, fi, fq}, {2'b10, 4'h3, 16'h1233});
        tx_wait(60);
        check({got, fg, fi, fq}, {2'b10, 4'h3, 16'h1233});
        check(wt, 22);
        @(posedge clk);
        txResendPause <= 1'b1;
        @(posedge clk);
        txResendPause <= 1'b0;
        tx_wait(8);
        check({got, fi}, {1'b1, 4'h3});
        axi_wr(REG_TXREQ, 32'h108);
        for (int k = 0; k < 6 && fi != 4'h8; k++)
            tx_wait(60);
        check({fg, fi, fq}, {1'b1, 4'h8, 16'h1238});
        axi_wr(REG_TXREQ, 32'h0);
        txGateIn <= 9'h1fe;
        repeat (40) @(posedge clk);
        axi_wr(REG_TXREQ, 32'h001);
        tx_wait(60);
        check(got, 1'b0);
        $display("test transmit done");
        give_verdict;
    end
endmodule // ethernet_pause_signal_interface_tb
